// [src/spl_pkg.sv]
// Shared constants for the system panel halt and load control block.
package spl_pkg;

  // ------------------------------------------------------------
  // Panel input vector layout
  // ------------------------------------------------------------
  localparam int IN_COUNT = 16;
  localparam int IN_HALT = 0;
  localparam int IN_GENERAL_CLEAR_BUTTON = 1;
  localparam int IN_LOAD = 2;
  localparam int IN_MEMORY_LOAD_SELECT = 3;
  localparam int IN_BOTTOM = 4;
  localparam int IN_PUSHDOWN = 5;
  localparam int IN_ALIGN = 6;
  localparam int IN_READ = 7;
  localparam int IN_WRITE = 8;
  localparam int IN_PWR_ON = 9;
  localparam int IN_PWR_OFF = 10;
  localparam int IN_COND_HALT = 11;
  localparam int IN_EOO_HALT = 12;
  localparam int IN_MEM_TARGET = 13;
  localparam int IN_ROUTE = 14;
  localparam int IN_POWERED = 15;

  // ------------------------------------------------------------
  // Operator codes
  // ------------------------------------------------------------
  localparam logic [7:0] OPC_HALT = 8'hdf;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;

  // Status register fields.
  localparam int ST_HALT_REQ = 0;
  localparam int ST_HALTED = 1;
  localparam int ST_MEMORY_LOAD_SELECT = 2;
  localparam int ST_POWERED = 3;
  localparam int ST_ROUTE_MNT = 4;
  localparam int ST_HOLD_N = 5;
  localparam int ST_MP_HALTED = 6;
  localparam int ST_WIDTH = 7;

  // Command register fields; writes of one are single actions.
  localparam int CMD_RESUME = 0;
  localparam int CMD_GENERAL_CLEAR_BUTTON = 1;
  localparam int CMD_HALT = 2;
  localparam int CMD_HOLD_RELEASE = 3;

  // Reset values.
  localparam logic RST_HOLD_N = 1'b1;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage

// [src/spl_btn_if.sv]
// Carrier for synchronised panel levels and their press and release pulses.
`timescale 1ns/1ps
`default_nettype none
interface spl_btn_if;
  import spl_pkg::*;
  logic [IN_COUNT-1:0] level;
  logic [IN_COUNT-1:0] press;
  logic [IN_COUNT-1:0] release_p;
  modport src (output level, output press, output release_p);
  modport dst (input level, input press, input release_p);
endinterface
`default_nettype wire

// [src/spl_sync.sv]
// Three-stage synchroniser and edge pulse generator for every panel input.
`timescale 1ns/1ps
`default_nettype none
module spl_sync (
  input wire logic core_clk, // CPU clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [spl_pkg::IN_COUNT-1:0] raw, // Unsynchronised panel inputs
  spl_btn_if.src btn // Synchronised levels and pulses
);
  import spl_pkg::*;

  logic [IN_COUNT-1:0] meta;
  logic [IN_COUNT-1:0] stable;
  logic [IN_COUNT-1:0] last;

  // ------------------------------------------------------------
  // Per-input synchroniser
  // ------------------------------------------------------------
  // Only the second and third stages are looked at, so metastability stays in the first.
  for (genvar i = 0; i < IN_COUNT; i++) begin : g_in
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        meta[i] <= 1'b0;
        stable[i] <= 1'b0;
        last[i] <= 1'b0;
        btn.press[i] <= 1'b0;
        btn.release_p[i] <= 1'b0;
      end else begin
        meta[i] <= raw[i];
        stable[i] <= meta[i];
        last[i] <= stable[i];
        btn.press[i] <= stable[i] & ~last[i];
        btn.release_p[i] <= ~stable[i] & last[i];
      end
    end
  end

  assign btn.level = last;

endmodule
`default_nettype wire

// [src/spl_panel_ctrl.sv]
// Top of the system panel halt, load, stack, memory and power control logic.
`timescale 1ns/1ps
`default_nettype none
module spl_panel_ctrl (
  input wire logic core_clk, // CPU clock, 20 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic halt_button, // Halt pushbutton
  input wire logic general_clear_button, // General clear pushbutton
  input wire logic load_button, // Load pushbutton
  input wire logic memory_load_button, // Memory-load selector pushbutton
  input wire logic bottom_button, // Bottom pushbutton of selector device
  input wire logic stack_pushdown_button, // First stack adjust pushbutton
  input wire logic stack_top_align_button, // Second stack adjust pushbutton
  input wire logic read_button, // Manual read pushbutton
  input wire logic write_button, // Manual write pushbutton
  input wire logic power_on_button, // Power on pushbutton
  input wire logic power_off_button, // Power off pushbutton
  input wire logic conditional_halt_select, // Conditional halt switch, high is up
  input wire logic eoo_halt_select, // End-of-operator halt switch, high is up
  input wire logic memory_target_select, // High selects main memory
  input wire logic panel_route_select, // High is maintenance position
  input wire logic powered_up, // Power cabinet reports system up
  input wire logic operator_end_signal, // End of current operator, CPU logic
  input wire logic operator_exec, // Operator opcode valid, CPU logic
  input wire logic [7:0] operator_code, // Executing opcode, CPU logic
  input wire logic mp_load_done, // Maintenance processor finished RAM load
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  output logic halt_request, // Halt request flip-flop
  output logic halted, // Halted flag, blocks next operator strobe
  output logic general_clear, // One-cycle general clear pulse
  output logic interface_hold_signal_n, // Message interface hold, active low
  output logic main_load_start, // Start main memory load routine
  output logic mp_ram_load_start, // Start processor RAM load
  output logic mp_ram_halted, // Processor halted after RAM load
  output logic stack_pushdown_req, // Push top-of-stack words to memory
  output logic stack_top_align_req, // Adjust stack until top word in first reg
  output logic mem_read_req, // One memory controller read cycle
  output logic mem_write_req, // One memory controller write cycle
  output logic mem_target_main, // High main memory, low IC address register
  output logic power_up_start, // Start power-up sequence
  output logic power_off_start, // Start power-off sequence
  output logic cpu_port_enable, // Panel connected to CPU control port
  output logic memory_load_select // Memory-load selector state
);
  import spl_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  logic [IN_COUNT-1:0] raw;
  spl_btn_if btn ();

  assign raw[IN_HALT] = halt_button;
  assign raw[IN_GENERAL_CLEAR_BUTTON] = general_clear_button;
  assign raw[IN_LOAD] = load_button;
  assign raw[IN_MEMORY_LOAD_SELECT] = memory_load_button;
  assign raw[IN_BOTTOM] = bottom_button;
  assign raw[IN_PUSHDOWN] = stack_pushdown_button;
  assign raw[IN_ALIGN] = stack_top_align_button;
  assign raw[IN_READ] = read_button;
  assign raw[IN_WRITE] = write_button;
  assign raw[IN_PWR_ON] = power_on_button;
  assign raw[IN_PWR_OFF] = power_off_button;
  assign raw[IN_COND_HALT] = conditional_halt_select;
  assign raw[IN_EOO_HALT] = eoo_halt_select;
  assign raw[IN_MEM_TARGET] = memory_target_select;
  assign raw[IN_ROUTE] = panel_route_select;
  assign raw[IN_POWERED] = powered_up;

  spl_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw(raw),
    .btn(btn)
  );

  // ------------------------------------------------------------
  // Routing and qualified actions
  // ------------------------------------------------------------
  logic cpu_route;
  logic act_halt;
  logic act_general_clear_button_btn;
  logic act_load_press;
  logic act_load_release;
  logic cond_halt_hit;
  logic eoo_enable;
  logic sw_write;
  logic sw_resume;
  logic sw_general_clear_button;
  logic sw_halt;
  logic sw_hold_release;
  logic do_general_clear_button;
  logic halt_set;
  logic load_main_pending;

  // In maintenance position the CPU function controls are cut off;
  // load and power controls keep working in either position.
  assign cpu_route = ~btn.level[IN_ROUTE];
  assign act_halt = (btn.release_p[IN_HALT] & cpu_route) | sw_halt;
  assign act_general_clear_button_btn = btn.release_p[IN_GENERAL_CLEAR_BUTTON] & cpu_route;
  assign act_load_press = btn.press[IN_LOAD];
  assign act_load_release = btn.release_p[IN_LOAD];

  // The opcode compare also needs the conditional halt switch up and normal routing, and it
  // fires whatever the halt button, the end-of-operator switch or the halted flag are doing.
  assign cond_halt_hit = operator_exec & (operator_code == OPC_HALT)
                         & btn.level[IN_COND_HALT] & cpu_route;
  assign eoo_enable = btn.level[IN_EOO_HALT] & cpu_route;

  // In normal routing position a main memory load begins with a general clear on the press.
  assign do_general_clear_button = act_general_clear_button_btn | sw_general_clear_button
                   | (act_load_press & memory_load_select & cpu_route);

  // A press while halted changes nothing; the conditional halt is its own path.
  assign halt_set = (act_halt & ~halted) | cond_halt_hit;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  assign sw_write = psel & penable & pready & pwrite & (paddr == ADDR_COMMAND);
  assign sw_resume = sw_write & pwdata[CMD_RESUME];
  assign sw_general_clear_button = sw_write & pwdata[CMD_GENERAL_CLEAR_BUTTON];
  assign sw_halt = sw_write & pwdata[CMD_HALT];
  assign sw_hold_release = sw_write & pwdata[CMD_HOLD_RELEASE];

  logic [ST_WIDTH-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[ST_HALT_REQ] = halt_request;
    status_word[ST_HALTED] = halted;
    status_word[ST_MEMORY_LOAD_SELECT] = memory_load_select;
    status_word[ST_POWERED] = btn.level[IN_POWERED];
    status_word[ST_ROUTE_MNT] = btn.level[IN_ROUTE];
    status_word[ST_HOLD_N] = interface_hold_signal_n;
    status_word[ST_MP_HALTED] = mp_ram_halted;
  end

  // Ready is raised during the access phase that follows each setup
  // cycle, so every transfer takes exactly two cycles.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= RST_RDATA;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= RST_RDATA;
      pslverr <= 1'b0;
      if (paddr == ADDR_STATUS) begin
        if (!pwrite) begin
          prdata <= {{(32-ST_WIDTH){1'b0}}, status_word};
        end else begin
          pslverr <= 1'b1;
        end
      end else if (paddr != ADDR_COMMAND) begin
        pslverr <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Halt control
  // ------------------------------------------------------------
  // The request is consumed when the processor halts; a new request in
  // the same cycle as that halt is kept, so no event is lost.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      halt_request <= 1'b0;
    end else if (do_general_clear_button) begin
      halt_request <= 1'b0;
    end else if (halt_set) begin
      halt_request <= 1'b1;
    end else if (operator_end_signal & halt_request) begin
      halt_request <= 1'b0;
    end
  end

  // Halted blocks the strobe for the next operator; it stays until a
  // software resume or a general clear.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      halted <= 1'b0;
    end else if (do_general_clear_button) begin
      halted <= 1'b0;
    end else if (operator_end_signal & (halt_request | eoo_enable)) begin
      halted <= 1'b1;
    end else if (sw_resume) begin
      halted <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // General clear and hold signal
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      general_clear <= 1'b0;
    end else begin
      general_clear <= do_general_clear_button;
    end
  end

  // The hold line initialises to its set level, unlike the other state.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      interface_hold_signal_n <= RST_HOLD_N;
    end else if (do_general_clear_button) begin
      interface_hold_signal_n <= RST_HOLD_N;
    end else if (sw_hold_release) begin
      interface_hold_signal_n <= ~RST_HOLD_N;
    end
  end

  // ------------------------------------------------------------
  // Memory-load selector
  // ------------------------------------------------------------
  // Clearing needs both buttons down together; the release of the
  // selector button is the moment of decision.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      memory_load_select <= 1'b0;
    end else if (btn.release_p[IN_MEMORY_LOAD_SELECT]) begin
      memory_load_select <= ~btn.level[IN_BOTTOM];
    end
  end

  // ------------------------------------------------------------
  // Load sequences
  // ------------------------------------------------------------
  // The selector is sampled on the press, so a change between press and
  // release cannot turn a cleared system into a RAM load.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      load_main_pending <= 1'b0;
    end else if (act_load_press) begin
      load_main_pending <= memory_load_select;
    end else if (act_load_release) begin
      load_main_pending <= 1'b0;
    end
  end

  // The block does not check that the CPU is halted before a load; the
  // operator is expected to halt it first.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      main_load_start <= 1'b0;
      mp_ram_load_start <= 1'b0;
    end else begin
      main_load_start <= act_load_release & load_main_pending;
      mp_ram_load_start <= act_load_release & ~load_main_pending;
    end
  end

  // After a RAM load the maintenance processor sits halted at the RAM
  // start address until it is initialised again.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mp_ram_halted <= 1'b0;
    end else if (mp_load_done) begin
      mp_ram_halted <= 1'b1;
    end else if (do_general_clear_button | mp_ram_load_start) begin
      mp_ram_halted <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Stack adjustment
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stack_pushdown_req <= 1'b0;
      stack_top_align_req <= 1'b0;
    end else begin
      stack_pushdown_req <= btn.release_p[IN_PUSHDOWN] & cpu_route;
      stack_top_align_req <= btn.release_p[IN_ALIGN] & cpu_route;
    end
  end

  // ------------------------------------------------------------
  // Manual memory cycles
  // ------------------------------------------------------------
  // The target follows the switch continuously so it is already stable
  // when a read or write request pulse is raised.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_target_main <= 1'b0;
    end else begin
      mem_target_main <= btn.level[IN_MEM_TARGET];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_read_req <= 1'b0;
      mem_write_req <= 1'b0;
    end else begin
      mem_read_req <= btn.release_p[IN_READ] & cpu_route;
      mem_write_req <= btn.release_p[IN_WRITE] & cpu_route;
    end
  end

  // ------------------------------------------------------------
  // Power sequencing
  // ------------------------------------------------------------
  // Power control works in either routing position.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_up_start <= 1'b0;
      power_off_start <= 1'b0;
    end else begin
      power_up_start <= btn.release_p[IN_PWR_ON] & ~btn.level[IN_POWERED];
      power_off_start <= btn.release_p[IN_PWR_OFF] & btn.level[IN_POWERED];
    end
  end

  // ------------------------------------------------------------
  // Routing indication
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_port_enable <= 1'b0;
    end else begin
      cpu_port_enable <= cpu_route;
    end
  end

endmodule
`default_nettype wire

// [tb/spl_cpu_model.sv]
// Behavioural model of the CPU operator sequencer and maintenance processor.
`timescale 1ns/1ps
`default_nettype none
module spl_cpu_model (
  input wire logic core_clk, // CPU clock
  input wire logic nrst, // Reset, active low
  input wire logic halted, // Blocks the next operator
  input wire logic load_start, // RAM load request
  input wire logic [7:0] next_code, // Opcode of coming operators
  output logic op_end, // Last cycle of an operator
  output logic op_exec, // First cycle of an operator
  output logic [7:0] op_code, // Opcode, scrambled outside exec
  output logic load_done // RAM load finished
);
  logic [1:0] phase;
  logic [3:0] load_dly;
  // Operators take four cycles; a set halted flag parks the sequencer
  // before the strobe of the next operator.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      phase <= 2'h0;
    else if (!(halted && phase == 2'h0))
      phase <= phase + 2'h1;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      load_dly <= 4'h0;
    else
      load_dly <= {load_dly[2:0], load_start};
  end
  assign op_exec = phase == 2'h0 && !halted;
  assign op_end = phase == 2'h3;
  assign op_code = op_exec ? next_code : ~next_code;
  assign load_done = load_dly[3];
endmodule
`default_nettype wire

// [tb/spl_panel_ctrl_assertions.sv]
// Port relation checker for the panel halt and load control block.
`timescale 1ns/1ps
`default_nettype none
module spl_panel_ctrl_assertions import spl_pkg::*; (
  input wire logic core_clk, // CPU clock
  input wire logic nrst, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic halt_request, // Halt request
  input wire logic halted, // Halted flag
  input wire logic general_clear, // Clear pulse
  input wire logic operator_end_signal, // Operator end
  input wire logic operator_exec, // Opcode valid
  input wire logic [7:0] operator_code, // Opcode
  input wire logic conditional_halt_select, // Conditional halt switch
  input wire logic panel_route_select, // Route switch
  input wire logic cpu_port_enable, // CPU port open
  input wire logic powered_up, // Power state
  input wire logic power_up_start, // Power-up pulse
  input wire logic power_off_start, // Power-off pulse
  input wire logic memory_target_select, // Target switch
  input wire logic mem_target_main, // Target output
  input wire logic mem_read_req, // Read pulse
  input wire logic mem_write_req // Write pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic cmd_wr = psel && penable && pwrite && paddr == ADDR_COMMAND;
  sequence route_held_mnt;
    panel_route_select [*8];
  endsequence
  sequence route_held_nml;
    !panel_route_select [*8];
  endsequence
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  chk_unmapped_err: assert property (psel && penable && pready && paddr != ADDR_STATUS
    && paddr != ADDR_COMMAND |-> pslverr) else $error("unmapped access without error");
  chk_halted_set: assert property (
    operator_end_signal && halt_request |=> halted || general_clear)
    else $error("halted not set at operator end");
  chk_halted_leave: assert property ($fell(halted) |-> general_clear
    || $past(general_clear) || $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("halted cleared without cause");
  chk_cond_halt: assert property (operator_exec && operator_code == OPC_HALT
    && $past(conditional_halt_select, 3) && !$past(panel_route_select, 3)
    |=> halt_request || general_clear)
    else $error("conditional halt missed");
  chk_route_block: assert property (route_held_mnt |-> !cpu_port_enable)
    else $error("cpu port open in maintenance");
  chk_route_normal: assert property (route_held_nml |-> cpu_port_enable)
    else $error("cpu port closed in normal");
  chk_power_on: assert property (power_up_start |-> !$past(powered_up, 4))
    else $error("power up while powered");
  chk_power_off: assert property (power_off_start |-> $past(powered_up, 4))
    else $error("power off while down");
  chk_mem_target: assert property (
    mem_read_req || mem_write_req |-> mem_target_main == $past(memory_target_select, 4))
    else $error("memory target wrong");
  chk_read_single: assert property (mem_read_req |=> !mem_read_req)
    else $error("read pulse too long");
endmodule
bind spl_panel_ctrl spl_panel_ctrl_assertions spl_panel_ctrl_assertions_i (.*);
`default_nettype wire

// [tb/spl_panel_ctrl_tb.sv]
// Self-checking bench for the panel halt and load control block.
`timescale 1ns/1ps
`default_nettype none
module spl_panel_ctrl_tb;
  import spl_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic conditional_halt_select = 1'b0, eoo_halt_select = 1'b0, powered_up = 1'b0;
  logic memory_target_select = 1'b0, panel_route_select = 1'b0;
  logic [10:0] btn = 11'h0;
  logic [7:0] paddr = 8'h00, code = 8'h00, operator_code;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, halt_request, halted, interface_hold_signal_n, mp_ram_halted, er;
  logic mem_target_main, cpu_port_enable, memory_load_select;
  logic operator_end_signal, operator_exec, mp_load_done;
  wire [8:0] pulse;
  int n_fail = 0, checked = 0, cyc = 0;
  int cnt [9], base [9];
  initial forever #25 core_clk = ~core_clk;
  spl_panel_ctrl spl_panel_ctrl_i (.*, .halt_button(btn[IN_HALT]),
    .general_clear_button(btn[IN_GENERAL_CLEAR_BUTTON]), .load_button(btn[IN_LOAD]),
    .memory_load_button(btn[IN_MEMORY_LOAD_SELECT]), .bottom_button(btn[IN_BOTTOM]),
    .stack_pushdown_button(btn[IN_PUSHDOWN]), .stack_top_align_button(btn[IN_ALIGN]),
    .read_button(btn[IN_READ]), .write_button(btn[IN_WRITE]),
    .power_on_button(btn[IN_PWR_ON]), .power_off_button(btn[IN_PWR_OFF]),
    .general_clear(pulse[0]), .main_load_start(pulse[1]), .mp_ram_load_start(pulse[2]),
    .stack_pushdown_req(pulse[3]), .stack_top_align_req(pulse[4]),
    .mem_read_req(pulse[5]), .mem_write_req(pulse[6]), .power_up_start(pulse[7]),
    .power_off_start(pulse[8]));
  spl_cpu_model spl_cpu_model_i (.core_clk(core_clk), .nrst(nrst), .halted(halted),
    .load_start(pulse[2]), .next_code(code), .op_end(operator_end_signal),
    .op_exec(operator_exec), .op_code(operator_code), .load_done(mp_load_done));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic print_verdict;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 9; i++) if (pulse[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Every pulse output must fire exactly as often as the mask says.
  task automatic press(input int b, input logic [8:0] exp);
    logic [8:0] one, more;
    base = cnt;
    @(posedge core_clk);
    btn[b] <= 1'b1;
    tick(4);
    @(posedge core_clk);
    btn[b] <= 1'b0;
    tick(10);
    for (int i = 0; i < 9; i++) begin
      one[i] = (cnt[i] - base[i]) == 1;
      more[i] = (cnt[i] - base[i]) > 1;
    end
    check({more, one}, {9'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    check(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(2);
  endtask
  task automatic wait_halt;
    for (int i = 0; i < 40 && halted !== 1'b1; i++) @(negedge core_clk);
    check(halted, 1'b1);
  endtask
  task automatic set_sw(input logic c, input logic e, input logic [7:0] op);
    @(posedge core_clk);
    conditional_halt_select <= c;
    eoo_halt_select <= e;
    code <= op;
    tick(6);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h1 << ST_HOLD_N);
    check(cpu_port_enable, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hff);
    check(er, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_halt;
    press(IN_HALT, 9'h0);
    wait_halt();
    press(IN_HALT, 9'h0);
    apb(1'b1, ADDR_COMMAND, 32'h1 << CMD_RESUME);
    tick(20);
    check(halted, 1'b0);
    $display("test halt done");
  endtask
  task automatic t_select_halts;
    set_sw(1'b1, 1'b0, 8'hde);
    tick(30);
    check(halted | halt_request, 1'b0);
    set_sw(1'b1, 1'b0, OPC_HALT);
    wait_halt();
    set_sw(1'b0, 1'b1, 8'hde);
    apb(1'b1, ADDR_COMMAND, 32'h1 << CMD_RESUME);
    check(halted, 1'b0);
    wait_halt();
    set_sw(1'b0, 1'b0, 8'hde);
    apb(1'b1, ADDR_COMMAND, 32'h1 << CMD_RESUME);
    tick(30);
    check(halted, 1'b0);
    $display("test selectors done");
  endtask
  task automatic t_actions;
    press(IN_PUSHDOWN, 9'h008);
    press(IN_ALIGN, 9'h010);
    for (int t = 0; t < 2; t++) begin
      @(posedge core_clk);
      memory_target_select <= t[0];
      powered_up <= t[0];
      tick(5);
      press(IN_READ, 9'h020);
      check(mem_target_main, t[0]);
      press(IN_WRITE, 9'h040);
      press(IN_PWR_ON, t[0] ? 9'h0 : 9'h080);
      press(IN_PWR_OFF, t[0] ? 9'h100 : 9'h0);
    end
    $display("test actions done");
  endtask
  task automatic t_load;
    press(IN_HALT, 9'h0);
    wait_halt();
    press(IN_MEMORY_LOAD_SELECT, 9'h0);
    press(IN_MEMORY_LOAD_SELECT, 9'h0);
    check(memory_load_select, 1'b1);
    press(IN_LOAD, 9'h003);
    press(IN_MEMORY_LOAD_SELECT, 9'h0);
    @(posedge core_clk);
    btn[IN_BOTTOM] <= 1'b1;
    press(IN_MEMORY_LOAD_SELECT, 9'h0);
    @(posedge core_clk);
    btn[IN_BOTTOM] <= 1'b0;
    check(memory_load_select, 1'b0);
    press(IN_LOAD, 9'h004);
    tick(6);
    check(mp_ram_halted, 1'b1);
    $display("test load done");
  endtask
  task automatic t_route_clear;
    @(posedge core_clk);
    panel_route_select <= 1'b1;
    tick(8);
    check(cpu_port_enable, 1'b0);
    press(IN_HALT, 9'h0);
    press(IN_READ, 9'h0);
    check(halt_request | halted, 1'b0);
    @(posedge core_clk);
    panel_route_select <= 1'b0;
    tick(8);
    press(IN_HALT, 9'h0);
    wait_halt();
    apb(1'b1, ADDR_COMMAND, 32'h1 << CMD_HOLD_RELEASE);
    check(interface_hold_signal_n, 1'b0);
    press(IN_GENERAL_CLEAR_BUTTON, 9'h001);
    check({interface_hold_signal_n, halted}, 2'b10);
    $display("test route and clear done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    tick(6);
    t_regs();
    t_halt();
    t_select_halts();
    t_actions();
    t_load();
    t_route_clear();
    print_verdict();
  end
endmodule
`default_nettype wire
